/* File: ctrl_regs_pkg.sv */
package ctrl_regs_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] BOOST_THERMAL_OFFSET = 8'h06;
	localparam logic [7:0] MISC_OP_OFFSET       = 8'h07;
	localparam logic [7:0] BOOST_THERMAL_RESET  = 8'h73;
	localparam logic [7:0] MISC_OP_RESET        = 8'h4b;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BOOST_VOLTAGE_CODE_LSB       = 4;
	localparam int BHOT_LSB         = 2;
	localparam int THERMAL_REG_THRESHOLD_LSB         = 0;
	localparam int FORCE_DETECT_BIT = 7;
	localparam int HALF_RATE_BIT    = 6;
	localparam int SWITCH_OFF_BIT   = 5;
	localparam int CHG_INT_EN_BIT   = 1;
	localparam int BAT_INT_EN_BIT   = 0;

	// ------------------------------------------------------------
	// analog codes
	// ------------------------------------------------------------
	localparam int BOOST_BASE_MV    = 4550;
	localparam int BOOST_STEP_MV    = 64;
	localparam logic [1:0] HOT_LEVEL_33  = 2'h0;
	localparam logic [1:0] HOT_LEVEL_36  = 2'h1;
	localparam logic [1:0] HOT_LEVEL_30  = 2'h2;
	localparam logic [1:0] HOT_PROT_OFF  = 2'h3;

	typedef enum logic [1:0] {
		DET_IDLE,
		DET_RUN
	} detect_state_e;

endpackage : ctrl_regs_pkg

/* File: source_detect_seq.sv */
`timescale 1ns/1ns
`default_nettype none

// one pending detection request, finished by the detector's done strobe
module source_detect_seq (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic input_present,
	input  wire logic detect_done,
	output var  logic detect_start,
	output var  logic busy
);
	import ctrl_regs_pkg::*;

	detect_state_e state_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg    <= DET_IDLE;
			detect_start <= 1'b0;
		end else begin
			detect_start <= 1'b0;
			unique case (state_reg)
				DET_IDLE: begin
					if (start && input_present) begin
						state_reg    <= DET_RUN;
						detect_start <= 1'b1;
					end
				end
				DET_RUN: begin
					if (detect_done) begin
						state_reg <= DET_IDLE;
					end
				end
				default: state_reg <= DET_IDLE;
			endcase
		end
	end

	assign busy = (state_reg == DET_RUN);

endmodule : source_detect_seq

`default_nettype wire

/* File: boost_thermal_misc_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - boost voltage code is 4 bits weighted 512/256/128/64 mV over 4.55 V, reset 0111.
// - hot select 00/01/10 picks 33%/36%/30% of the regulator rail, 11 disables protection.
// - with hot select 11 boost keeps running and the thermistor fault uses the 33% level.
// - thermal regulation select 00..11 means 60/80/100/120 C, reset 11.
// - writing 1 to bit 7 starts source detection with input present; it clears when done.
// - bit 6 set halves the safety timer rate during power limiting or thermal regulation.
// - bit 5 set forces the battery switch off; 0 lets it turn on.
// - bit 1 lets a charge fault raise the interrupt.
// - bit 0 lets a battery fault raise the interrupt.
// - the misc register resets to 01001011.
module boost_thermal_misc_control_regs (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] rd_addr,
	output var  logic [7:0] rd_data,
	input  wire logic       input_present,
	input  wire logic       detect_done,
	input  wire logic       boost_mode,
	input  wire logic       thermistor_hot_33,
	input  wire logic       thermistor_hot_36,
	input  wire logic       thermistor_hot_30,
	input  wire logic       input_power_limiting,
	input  wire logic       thermal_regulating,
	input  wire logic       charge_fault,
	input  wire logic       battery_fault,
	output var  logic [3:0] boost_voltage_code,
	output var  logic [1:0] thermal_reg_threshold,
	output var  logic       boost_hot_shutdown,
	output var  logic       thermistor_fault,
	output var  logic       detect_start,
	output var  logic       timer_half_rate,
	output var  logic       battery_switch_off,
	output var  logic       fault_int
);
	import ctrl_regs_pkg::*;

	logic [7:0] boost_thermal_ctrl_reg;
	logic [7:0] misc_operation_ctrl_reg;
	logic       force_set;
	logic       detect_busy;
	logic       detect_start_w;
	logic       seen_busy_reg;
	logic       hot_sel_level;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	assign force_set = wr_en && (wr_addr == MISC_OP_OFFSET) && wr_data[FORCE_DETECT_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boost_thermal_ctrl_reg <= BOOST_THERMAL_RESET;
		end else if (wr_en && wr_addr == BOOST_THERMAL_OFFSET) begin
			boost_thermal_ctrl_reg <= wr_data;
		end
	end

	// force bit: host write sets, completion clears; a new write wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			misc_operation_ctrl_reg <= MISC_OP_RESET;
			seen_busy_reg           <= 1'b0;
		end else begin
			if (wr_en && wr_addr == MISC_OP_OFFSET) begin
				misc_operation_ctrl_reg <= wr_data;
			end
			seen_busy_reg <= force_set ? 1'b0 : (seen_busy_reg | detect_busy);
			if (!force_set && misc_operation_ctrl_reg[FORCE_DETECT_BIT]
			    && (seen_busy_reg || !input_present) && !detect_busy) begin
				misc_operation_ctrl_reg[FORCE_DETECT_BIT] <= 1'b0;
			end
		end
	end

	source_detect_seq u_detect (
		.clk          (clk),
		.rst          (rst),
		.start        (misc_operation_ctrl_reg[FORCE_DETECT_BIT] && !seen_busy_reg),
		.input_present(input_present),
		.detect_done  (detect_done),
		.detect_start (detect_start_w),
		.busy         (detect_busy)
	);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else begin
			unique case (rd_addr)
				BOOST_THERMAL_OFFSET: rd_data <= boost_thermal_ctrl_reg;
				MISC_OP_OFFSET:       rd_data <= misc_operation_ctrl_reg;
				default:              rd_data <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// hot threshold selection
	// ------------------------------------------------------------
	always_comb begin
		unique case (boost_thermal_ctrl_reg[BHOT_LSB +: 2])
			HOT_LEVEL_36: hot_sel_level = thermistor_hot_36;
			HOT_LEVEL_30: hot_sel_level = thermistor_hot_30;
			HOT_LEVEL_33, HOT_PROT_OFF: hot_sel_level = thermistor_hot_33;
		endcase
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boost_voltage_code    <= BOOST_THERMAL_RESET[BOOST_VOLTAGE_CODE_LSB +: 4];
			thermal_reg_threshold <= BOOST_THERMAL_RESET[THERMAL_REG_THRESHOLD_LSB +: 2];
			boost_hot_shutdown    <= 1'b0;
			thermistor_fault      <= 1'b0;
			detect_start          <= 1'b0;
			timer_half_rate       <= 1'b0;
			battery_switch_off    <= 1'b0;
			fault_int             <= 1'b0;
		end else begin
			boost_voltage_code    <= boost_thermal_ctrl_reg[BOOST_VOLTAGE_CODE_LSB +: 4];
			thermal_reg_threshold <= boost_thermal_ctrl_reg[THERMAL_REG_THRESHOLD_LSB +: 2];
			// protection off: boost never shut down, fault still at 33%
			boost_hot_shutdown <= boost_mode && hot_sel_level
				&& (boost_thermal_ctrl_reg[BHOT_LSB +: 2] != HOT_PROT_OFF);
			thermistor_fault   <= boost_mode && hot_sel_level;
			detect_start       <= detect_start_w;
			timer_half_rate    <= misc_operation_ctrl_reg[HALF_RATE_BIT]
				&& (input_power_limiting || thermal_regulating);
			battery_switch_off <= misc_operation_ctrl_reg[SWITCH_OFF_BIT];
			fault_int <= (charge_fault && misc_operation_ctrl_reg[CHG_INT_EN_BIT])
				|| (battery_fault && misc_operation_ctrl_reg[BAT_INT_EN_BIT]);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_misc_reset_value: assert property (@(posedge clk)
		$fell(rst) |-> misc_operation_ctrl_reg == MISC_OP_RESET)
		else $error("misc register reset value wrong");

	a_boost_code_follow: assert property (@(posedge clk) disable iff (rst)
		wr_en && wr_addr == BOOST_THERMAL_OFFSET
		|-> ##2 boost_voltage_code == $past(wr_data[7:4], 2))
		else $error("boost code not applied");

	a_hot_disable_none: assert property (@(posedge clk) disable iff (rst)
		boost_thermal_ctrl_reg[3:2] == 2'h3 |=> !boost_hot_shutdown)
		else $error("shutdown with protection off");

	a_fault_at_first: assert property (@(posedge clk) disable iff (rst)
		boost_thermal_ctrl_reg[3:2] == 2'h3 && boost_mode && thermistor_hot_33
		|=> thermistor_fault)
		else $error("thermistor fault missing");

	a_thermal_reg_threshold_follow: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> thermal_reg_threshold == $past(boost_thermal_ctrl_reg[1:0]))
		else $error("thermal threshold mismatch");

	a_detect_launch: assert property (@(posedge clk) disable iff (rst)
		force_set && input_present && !detect_busy && !misc_operation_ctrl_reg[7]
		|-> ##3 detect_start)
		else $error("detection not started");

	a_half_rate_gate: assert property (@(posedge clk) disable iff (rst)
		!misc_operation_ctrl_reg[6] |=> !timer_half_rate)
		else $error("half rate without enable");

	a_switch_off: assert property (@(posedge clk) disable iff (rst)
		misc_operation_ctrl_reg[5] |=> battery_switch_off)
		else $error("battery switch not forced off");

	a_chg_int_mask: assert property (@(posedge clk) disable iff (rst)
		charge_fault && misc_operation_ctrl_reg[1] |=> fault_int)
		else $error("charge fault interrupt missing");

	a_bat_int_mask: assert property (@(posedge clk) disable iff (rst)
		battery_fault && !charge_fault && !misc_operation_ctrl_reg[0] |=> !fault_int)
		else $error("masked battery fault interrupted");

	a_bat_int_pass: assert property (@(posedge clk) disable iff (rst)
		battery_fault && misc_operation_ctrl_reg[BAT_INT_EN_BIT] |=> fault_int)
		else $error("battery fault interrupt missing");

	a_chg_int_block: assert property (@(posedge clk) disable iff (rst)
		charge_fault && !battery_fault && !misc_operation_ctrl_reg[CHG_INT_EN_BIT]
		|=> !fault_int)
		else $error("masked charge fault interrupted");

	a_half_rate_on: assert property (@(posedge clk) disable iff (rst)
		misc_operation_ctrl_reg[HALF_RATE_BIT] && (input_power_limiting || thermal_regulating)
		|=> timer_half_rate)
		else $error("half rate missing");

	a_switch_allow: assert property (@(posedge clk) disable iff (rst)
		!misc_operation_ctrl_reg[SWITCH_OFF_BIT] |=> !battery_switch_off)
		else $error("battery switch forced off without request");

	a_hot_shutdown_33: assert property (@(posedge clk) disable iff (rst)
		boost_thermal_ctrl_reg[3:2] == HOT_LEVEL_33 && boost_mode && thermistor_hot_33
		|=> boost_hot_shutdown)
		else $error("no shutdown at first hot level");

	a_hot_shutdown_30: assert property (@(posedge clk) disable iff (rst)
		boost_thermal_ctrl_reg[3:2] == HOT_LEVEL_30 && boost_mode && thermistor_hot_30
		|=> boost_hot_shutdown)
		else $error("no shutdown at third hot level");

	a_detect_clear: assert property (@(posedge clk) disable iff (rst)
		misc_operation_ctrl_reg[FORCE_DETECT_BIT] && !input_present && !force_set
		&& !detect_busy |=> !misc_operation_ctrl_reg[FORCE_DETECT_BIT])
		else $error("force bit kept without input");

	a_detect_pulse: assert property (@(posedge clk) disable iff (rst)
		detect_start |=> !detect_start)
		else $error("detection start longer than one cycle");

endmodule : boost_thermal_misc_control_regs

`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// host side of the register port, in place of the serial engine
module host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rd_data,
	output var  logic       wr_en,
	output var  logic [7:0] wr_addr,
	output var  logic [7:0] wr_data,
	output var  logic [7:0] rd_addr
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
	end
	// idle address and data are inverted so a stale byte cannot pass for a fresh one
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		rd_addr = a;
		@(negedge clk);
		d = rd_data;
	endtask : read
	// only masked bits change, reserved bits keep what was read back
	task automatic modify(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
		logic [7:0] d;
		read(a, d);
		write(a, (d & ~m) | (v & m));
	endtask : modify
endmodule : host_model

`default_nettype wire

/* File: boost_thermal_misc_control_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module boost_thermal_misc_control_regs_tb_top;
	import ctrl_regs_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       wr_en, input_present, detect_done, boost_mode, hot_33, hot_36, hot_30;
	logic       input_power_limiting, thermal_regulating, charge_fault, battery_fault;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, d;
	logic [3:0] boost_voltage_code;
	logic [1:0] thermal_reg_threshold;
	logic       boost_hot_shutdown, thermistor_fault, detect_start;
	logic       timer_half_rate, battery_switch_off, fault_int;
	int         check_count = 0;
	int         miscompares = 0;
	int         i;

	always #25 clk = ~clk;

	host_model host_model_inst (.clk(clk), .rd_data(rd_data), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr));

	boost_thermal_misc_control_regs boost_thermal_misc_control_regs_inst (.clk(clk),
		.rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_data(rd_data), .input_present(input_present), .detect_done(detect_done),
		.boost_mode(boost_mode), .thermistor_hot_33(hot_33), .thermistor_hot_36(hot_36),
		.thermistor_hot_30(hot_30), .input_power_limiting(input_power_limiting),
		.thermal_regulating(thermal_regulating), .charge_fault(charge_fault),
		.battery_fault(battery_fault), .boost_voltage_code(boost_voltage_code),
		.thermal_reg_threshold(thermal_reg_threshold),
		.boost_hot_shutdown(boost_hot_shutdown), .thermistor_fault(thermistor_fault),
		.detect_start(detect_start), .timer_half_rate(timer_half_rate),
		.battery_switch_off(battery_switch_off), .fault_int(fault_int));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{input_present, detect_done, boost_mode, hot_33, hot_36, hot_30} = 6'h00;
		{input_power_limiting, thermal_regulating, charge_fault, battery_fault} = 4'h0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		host_model_inst.read(BOOST_THERMAL_OFFSET, d);
		check(d, 8'h73);
		host_model_inst.read(MISC_OP_OFFSET, d);
		check(d, 8'h4b);
		check({4'h0, boost_voltage_code}, 8'h07);
		check({6'h0, thermal_reg_threshold}, 8'h03);
		host_model_inst.read(8'h08, d);
		check(d, 8'h00);
		host_model_inst.write(8'h05, 8'hff);
		host_model_inst.read(BOOST_THERMAL_OFFSET, d);
		check(d, 8'h73);
		$display("test reset_and_map done");
		// hot_36 low while the others are high tells the selects apart, except 00 from 10
		{boost_mode, hot_33, hot_30} = 3'h7;
		for (i = 0; i < 4; i++) begin
			d = {4'(i * 5), 2'(i), 2'(i)};
			host_model_inst.write(BOOST_THERMAL_OFFSET, d);
			@(negedge clk);
			check({4'h0, boost_voltage_code}, {4'h0, d[7:4]});
			check({6'h0, thermal_reg_threshold}, {6'h0, d[1:0]});
			check({7'h0, boost_hot_shutdown}, {7'h0, i[0] == 1'b0});
			check({7'h0, thermistor_fault}, {7'h0, i != 1});
		end
		$display("test boost_thermal done");
		input_power_limiting = 1'b1;
		charge_fault = 1'b1;
		host_model_inst.modify(MISC_OP_OFFSET, 8'h63, 8'h22);
		@(negedge clk);
		check({6'h0, timer_half_rate, battery_switch_off}, 8'h01);
		check({7'h0, fault_int}, 8'h01);
		host_model_inst.modify(MISC_OP_OFFSET, 8'h63, 8'h41);
		@(negedge clk);
		check({6'h0, timer_half_rate, battery_switch_off}, 8'h02);
		check({7'h0, fault_int}, 8'h00);
		{battery_fault, input_power_limiting, thermal_regulating} = 3'h5;
		repeat (2) @(negedge clk);
		check({7'h0, fault_int}, 8'h01);
		check({7'h0, timer_half_rate}, 8'h01);
		host_model_inst.read(MISC_OP_OFFSET, d);
		check(d, 8'h49);
		thermal_regulating = 1'b0;
		host_model_inst.modify(MISC_OP_OFFSET, 8'h03, 8'h00);
		@(negedge clk);
		check({6'h0, timer_half_rate, fault_int}, 8'h00);
		$display("test misc_controls done");
		input_present = 1'b1;
		host_model_inst.modify(MISC_OP_OFFSET, 8'h80, 8'h80);
		i = 0;
		while (detect_start !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		if (i >= 20) begin
			miscompares++;
			results();
		end
		check({7'h0, detect_start}, 8'h01);
		host_model_inst.read(MISC_OP_OFFSET, d);
		check(d, 8'hc8);
		check({7'h0, detect_start}, 8'h00);
		detect_done = 1'b1;
		@(negedge clk);
		detect_done = 1'b0;
		repeat (2) @(negedge clk);
		host_model_inst.read(MISC_OP_OFFSET, d);
		check(d, 8'h48);
		input_present = 1'b0;
		host_model_inst.modify(MISC_OP_OFFSET, 8'h80, 8'h80);
		repeat (3) @(negedge clk);
		host_model_inst.read(MISC_OP_OFFSET, d);
		check(d, 8'h48);
		$display("test source_detect done");
		// second reset after the registers were changed
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		host_model_inst.read(MISC_OP_OFFSET, d);
		check(d, 8'h4b);
		host_model_inst.read(BOOST_THERMAL_OFFSET, d);
		check(d, 8'h73);
		check({4'h0, boost_voltage_code}, 8'h07);
		$display("test mid_reset done");
		results();
	end
endmodule : boost_thermal_misc_control_regs_tb_top

`default_nettype wire
